// ===== core/adc_host.sv
/*
 * two-wire bus master that writes one command byte to the converter,
 * reads back the two result bytes and reports over AXI4-Lite.
 * assumes open-drain pads outside that resolve scl and sda from the
 * enables, and pull-ups that make a released line read high.
 */
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - start only while both lines idle high
// - change data only while clock low
// - start is data falling, clock high
// - stop is data rising, clock high
// - bytes msb first, ninth clock for ack
// - extra clock per ack, receiver holds low
// - release data after last byte for stop
// - master makes clocks, start, stop, repeated start
// - master acks all reads but last
// - read only after a command started conversion
module adc_host #(
    parameter logic [4:0] ADDR_PREFIX = adc_link_pkg::PREFIX_DEFAULT
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    input  wire logic        scl_i,
    output var  logic        scl_o,
    output var  logic        scl_oe,
    input  wire logic        sda_i,
    output var  logic        sda_o,
    output var  logic        sda_oe
);
    // ---------------------------------------------
    // state
    // ---------------------------------------------
    adc_link_pkg::link_state_type state, next_state;
    logic        aw_ok, next_aw_ok, w_ok, next_w_ok;
    logic [3:0]  awa, next_awa;
    logic [31:0] wd, next_wd;
    logic [3:0]  ws, next_ws;
    logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [7:0]  cmd, next_cmd;
    logic [1:0]  dsel, next_dsel;
    logic [15:0] div, next_div, qcnt, next_qcnt;
    logic        busy, next_busy, done, next_done, nack, next_nack;
    logic [11:0] result, next_result;
    logic [1:0]  quarter, next_quarter;
    logic [3:0]  bitn, next_bitn;
    logic [2:0]  op, next_op;
    logic [7:0]  shreg, next_shreg;
    logic        next_scl_oe, next_sda_oe;
    logic        scl_s1, scl_in, sda_s1, sda_in;
    logic        tick;

    // byte-lane merge of a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // address byte for one direction
    function automatic logic [7:0] addr_byte(input logic [1:0] sel, input logic rd);
        return {ADDR_PREFIX, sel, rd};
    endfunction : addr_byte

    // ---------------------------------------------
    // line synchronisers
    // ---------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_s1 <= 1'b1;
            scl_in <= 1'b1;
            sda_s1 <= 1'b1;
            sda_in <= 1'b1;
        end else begin
            scl_s1 <= scl_i;
            scl_in <= scl_s1;
            sda_s1 <= sda_i;
            sda_in <= sda_s1;
        end
    end

    assign tick = (qcnt == 16'h0000);

    // ---------------------------------------------
    // next-state logic: register bus and link
    // ---------------------------------------------
    always_comb begin
        logic [31:0] m;
        m            = 32'h0000_0000;
        next_state   = state;
        next_aw_ok   = aw_ok;
        next_w_ok    = w_ok;
        next_awa     = awa;
        next_wd      = wd;
        next_ws      = ws;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rresp   = rresp;
        next_rdata   = rdata;
        next_cmd     = cmd;
        next_dsel    = dsel;
        next_div     = div;
        next_busy    = busy;
        next_done    = done;
        next_nack    = nack;
        next_result  = result;
        next_quarter = quarter;
        next_bitn    = bitn;
        next_op      = op;
        next_shreg   = shreg;
        next_scl_oe  = scl_oe;
        next_sda_oe  = sda_oe;
        next_qcnt    = tick ? div : qcnt - 16'h0001;
        // write address and data are taken in either order
        if (awvalid && awready) begin
            next_aw_ok = 1'b1;
            next_awa   = awaddr;
        end
        if (wvalid && wready) begin
            next_w_ok = 1'b1;
            next_wd   = wdata;
            next_ws   = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_ok && w_ok && !bvalid) begin
            next_aw_ok  = 1'b0;
            next_w_ok   = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = adc_link_pkg::RESP_OKAY;
            unique case (awa)
                adc_link_pkg::CTRL_OFS: begin
                    m         = merge({22'h00_0000, dsel, cmd}, wd, ws);
                    next_cmd  = m[7:0];
                    next_dsel = m[adc_link_pkg::DSEL_LSB +: 2];
                    if (ws[2] && wd[adc_link_pkg::GO_BIT] && !busy) begin
                        next_busy    = 1'b1;
                        next_state   = adc_link_pkg::ST_START;
                        next_op      = adc_link_pkg::OP_ADDR_W;
                        next_shreg   = addr_byte(m[adc_link_pkg::DSEL_LSB +: 2], 1'b0);
                        next_quarter = 2'd0;
                        next_sda_oe  = 1'b0;
                        next_scl_oe  = 1'b0;
                    end
                end
                adc_link_pkg::STATUS_OFS: begin
                    if (ws[0] && wd[adc_link_pkg::DONE_BIT]) next_done = 1'b0;
                    if (ws[0] && wd[adc_link_pkg::NACK_BIT]) next_nack = 1'b0;
                end
                adc_link_pkg::DIV_OFS: begin
                    m        = merge({16'h0000, div}, wd, ws);
                    next_div = m[15:0];
                end
                adc_link_pkg::RESULT_OFS: begin
                end
                default: next_bresp = adc_link_pkg::RESP_SLVERR;
            endcase
        end
        // read channel
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp  = adc_link_pkg::RESP_OKAY;
            unique case (araddr)
                adc_link_pkg::CTRL_OFS:   next_rdata = {22'h00_0000, dsel, cmd};
                adc_link_pkg::STATUS_OFS: next_rdata = {29'h0000_0000, nack, done, busy};
                adc_link_pkg::RESULT_OFS: next_rdata = {20'h0_0000, result};
                adc_link_pkg::DIV_OFS:    next_rdata = {16'h0000, div};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = adc_link_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        // link sequencer, one step per quarter of a clock period
        if (tick) begin
            unique case (state)
                adc_link_pkg::ST_IDLE: begin
                end
                adc_link_pkg::ST_START: begin
                    if (quarter == 2'd0) begin
                        next_scl_oe  = 1'b0;
                        next_quarter = 2'd1;
                    end else if (quarter == 2'd1) begin
                        if (scl_in && sda_in) begin
                            next_sda_oe  = 1'b1;
                            next_quarter = 2'd2;
                        end
                    end else begin
                        next_scl_oe  = 1'b1;
                        next_state   = adc_link_pkg::ST_BIT;
                        next_quarter = 2'd3;
                        next_bitn    = adc_link_pkg::BIT_BEFORE;
                    end
                end
                adc_link_pkg::ST_BIT: begin
                    if (quarter == 2'd0) begin
                        next_scl_oe  = 1'b0;
                        next_quarter = 2'd1;
                    end else if (quarter == 2'd1) begin
                        if (scl_in) begin
                            next_quarter = 2'd2;
                            if (bitn < adc_link_pkg::BIT_ACK) begin
                                next_shreg = {shreg[6:0], sda_in};
                            end else if (op <= adc_link_pkg::OP_ADDR_R && sda_in) begin
                                next_nack = 1'b1;
                            end
                        end
                    end else if (quarter == 2'd2) begin
                        next_scl_oe  = 1'b1;
                        next_quarter = 2'd3;
                    end else if (bitn != adc_link_pkg::BIT_ACK) begin
                        // clock is low: set the next data bit
                        next_bitn    = bitn + 4'd1;
                        next_quarter = 2'd0;
                        if (next_bitn == adc_link_pkg::BIT_ACK) begin
                            next_sda_oe = (op == adc_link_pkg::OP_RD_HI);
                        end else begin
                            next_sda_oe = (op <= adc_link_pkg::OP_ADDR_R) ? !shreg[7] : 1'b0;
                        end
                    end else if (nack || op == adc_link_pkg::OP_RD_LO) begin
                        if (op == adc_link_pkg::OP_RD_LO) next_result[7:0] = shreg;
                        next_state   = adc_link_pkg::ST_STOP;
                        next_sda_oe  = 1'b1;
                        next_quarter = 2'd0;
                    end else if (op == adc_link_pkg::OP_CMD) begin
                        // repeated start keeps the bus for the read
                        next_op      = adc_link_pkg::OP_ADDR_R;
                        next_shreg   = addr_byte(dsel, 1'b1);
                        next_state   = adc_link_pkg::ST_START;
                        next_sda_oe  = 1'b0;
                        next_quarter = 2'd0;
                    end else begin
                        if (op == adc_link_pkg::OP_ADDR_W) next_shreg = cmd;
                        if (op == adc_link_pkg::OP_RD_HI) next_result[11:8] = shreg[3:0];
                        next_op   = op + 3'd1;
                        next_bitn = adc_link_pkg::BIT_BEFORE;
                    end
                end
                adc_link_pkg::ST_STOP: begin
                    if (quarter == 2'd0) begin
                        next_scl_oe  = 1'b0;
                        next_quarter = 2'd1;
                    end else if (quarter == 2'd1) begin
                        if (scl_in) begin
                            next_sda_oe  = 1'b0;
                            next_quarter = 2'd2;
                        end
                    end else begin
                        next_state = adc_link_pkg::ST_IDLE;
                        next_busy  = 1'b0;
                        next_done  = 1'b1;
                    end
                end
            endcase
        end
        next_awready = !next_aw_ok;
        next_wready  = !next_w_ok;
        next_arready = !next_rvalid;
    end

    // ---------------------------------------------
    // registers
    // ---------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state   <= adc_link_pkg::ST_IDLE;
            aw_ok   <= 1'b0;
            w_ok    <= 1'b0;
            awa     <= 4'h0;
            wd      <= 32'h0000_0000;
            ws      <= 4'h0;
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= adc_link_pkg::RESP_OKAY;
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rresp   <= adc_link_pkg::RESP_OKAY;
            rdata   <= 32'h0000_0000;
            cmd     <= 8'h00;    // power field 00 keeps reference off
            dsel    <= 2'h0;
            div     <= adc_link_pkg::DIV_RESET;
            qcnt    <= 16'h0000;
            busy    <= 1'b0;
            done    <= 1'b0;
            nack    <= 1'b0;
            result  <= 12'h000;
            quarter <= 2'd0;
            bitn    <= 4'h0;
            op      <= 3'h0;
            shreg   <= 8'h00;
            scl_oe  <= 1'b0;
            sda_oe  <= 1'b0;
            scl_o   <= 1'b0;
            sda_o   <= 1'b0;
        end else begin
            state   <= next_state;
            aw_ok   <= next_aw_ok;
            w_ok    <= next_w_ok;
            awa     <= next_awa;
            wd      <= next_wd;
            ws      <= next_ws;
            awready <= next_awready;
            wready  <= next_wready;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            arready <= next_arready;
            rvalid  <= next_rvalid;
            rresp   <= next_rresp;
            rdata   <= next_rdata;
            cmd     <= next_cmd;
            dsel    <= next_dsel;
            div     <= next_div;
            qcnt    <= next_qcnt;
            busy    <= next_busy;
            done    <= next_done;
            nack    <= next_nack;
            result  <= next_result;
            quarter <= next_quarter;
            bitn    <= next_bitn;
            op      <= next_op;
            shreg   <= next_shreg;
            scl_oe  <= next_scl_oe;
            sda_oe  <= next_sda_oe;
            scl_o   <= 1'b0;
            sda_o   <= 1'b0;
        end
    end

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    data_stable_a: assert property (state == adc_link_pkg::ST_BIT && !scl_oe && !$past(scl_oe)
        |-> $stable(sda_oe)) else $error("data moved while clock high");
    start_edge_a: assert property (state == adc_link_pkg::ST_START && $rose(sda_oe)
        |-> !scl_oe && $past(scl_in)) else $error("start not under high clock");
    stop_edge_a: assert property ($fell(sda_oe) && $past(state) == adc_link_pkg::ST_STOP
        |-> !scl_oe) else $error("stop not under high clock");
    bit_range_a: assert property (state == adc_link_pkg::ST_BIT
        |-> bitn <= adc_link_pkg::BIT_ACK || bitn == adc_link_pkg::BIT_BEFORE)
        else $error("bit index out of range");
    ack_free_a: assert property (state == adc_link_pkg::ST_BIT && bitn == adc_link_pkg::BIT_ACK
        && op <= adc_link_pkg::OP_ADDR_R |-> !sda_oe) else $error("data held during slave ack");
    last_nack_a: assert property (state == adc_link_pkg::ST_BIT && bitn == adc_link_pkg::BIT_ACK
        |-> sda_oe == (op == adc_link_pkg::OP_RD_HI)) else $error("wrong ack on read byte");
    idle_start_a: assert property (state == adc_link_pkg::ST_START && $rose(sda_oe)
        |-> $past(sda_in)) else $error("start on busy bus");
    stretch_hold_a: assert property (state == adc_link_pkg::ST_BIT && quarter == 2'd1 && !scl_in
        |=> quarter == 2'd1) else $error("clock stretch ignored");
    stop_done_a: assert property (state == adc_link_pkg::ST_STOP && quarter == 2'd2 && tick
        |=> state == adc_link_pkg::ST_IDLE && done && !busy) else $error("stop did not finish");
    resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");

    full_read_c: cover property (state == adc_link_pkg::ST_STOP && op == adc_link_pkg::OP_RD_LO && !nack);
    nack_seen_c: cover property ($rose(nack));
    stretch_c:   cover property ((state == adc_link_pkg::ST_BIT && quarter == 2'd1 && !scl_in) [*3]);
    rep_start_c: cover property (state == adc_link_pkg::ST_START && op == adc_link_pkg::OP_ADDR_R);
endmodule : adc_host

`default_nettype wire

// ===== core/adc_link_pkg.sv
/*
 * constants for the two-wire converter host: register map, field
 * positions, reset values, link timing and sequencer codes.
 * assumes a 200 MHz system clock and an AXI4-Lite register bus.
 */
package adc_link_pkg;
    // ---------------------------------------------
    // register map (byte offsets)
    // ---------------------------------------------
    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] RESULT_OFS = 4'h8;
    localparam logic [3:0] DIV_OFS    = 4'hC;
    // field positions
    localparam int GO_BIT   = 16;
    localparam int DSEL_LSB = 8;
    localparam int BUSY_BIT = 0;
    localparam int DONE_BIT = 1;
    localparam int NACK_BIT = 2;
    // ---------------------------------------------
    // timing: quarter of a standard-mode clock
    // ---------------------------------------------
    localparam int CLK_MHZ     = 200;
    localparam int SCL_STD_KHZ = 100;
    localparam logic [15:0] DIV_RESET = 16'(CLK_MHZ * 1000 / (SCL_STD_KHZ * 4));
    // address prefix default, value arbitrary
    localparam logic [4:0] PREFIX_DEFAULT = 5'h0B;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] BIT_BEFORE  = 4'hF;
    localparam logic [3:0] BIT_ACK     = 4'h8;
    // sequencer steps of one conversion transaction
    localparam logic [2:0] OP_ADDR_W = 3'h0;
    localparam logic [2:0] OP_CMD    = 3'h1;
    localparam logic [2:0] OP_ADDR_R = 3'h2;
    localparam logic [2:0] OP_RD_HI  = 3'h3;
    localparam logic [2:0] OP_RD_LO  = 3'h4;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_BIT   = 2'b11,
        ST_STOP  = 2'b10
    } link_state_type;
endpackage : adc_link_pkg

// ===== test/adc_host_tb.sv
/* self-checking bench for the converter host.
   assumes the slave model stands on the resolved two-wire lines. */
`timescale 1ns/100ps
`default_nettype none
module adc_host_tb;
    localparam logic [4:0] PREFIX = 5'h0D; // arbitrary prefix value
    localparam logic [1:0] DSEL   = 2'h2;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000, rdata, rng = 32'h00f5_34e9;
    logic        awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, scl_low, sda_low, in_frame, scl_o, sda_o;
    logic [1:0]  bresp, rresp, ack_seen;
    logic [7:0]  last_cmd;
    logic [15:0] stretch_ns = 16'h0000;
    logic [2:0]  n_conv = 3'h0;
    int          n_mismatch = 0, n_checks = 0, cycles = 0;
    wire         scl = (scl_oe ? scl_o : 1'b1) && !scl_low;
    wire         sda = (sda_oe ? sda_o : 1'b1) && !sda_low;
    adc_host #(.ADDR_PREFIX(PREFIX)) i_adc_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
    adc_slave_model #(.PREFIX(PREFIX), .DSEL(DSEL)) i_adc_slave_model (.scl(scl), .sda(sda),
        .stretch_ns(stretch_ns), .scl_low(scl_low), .sda_low(sda_low), .last_cmd(last_cmd),
        .ack_seen(ack_seen), .in_frame(in_frame));
    initial forever #2.5 aclk = !aclk;
    // hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch++;
            print_verdict;
        end
    end
    task automatic print_verdict;
        if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    // expected result word: positive input, negative input, power bits, conversion count
    function automatic logic [31:0] exp_result(input logic [7:0] c, input logic [2:0] n);
        logic [2:0] p;
        logic [3:0] m;
        p = 3'(2 * c[5:4] + c[6]);
        m = c[7] ? 4'h8 : 4'(2 * c[5:4] + !c[6]);
        return {20'h0_0000, p, m, c[3], c[2], n};
    endfunction : exp_result
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done, w_done;
        @(posedge aclk);
        {aw_done, w_done} = 2'h0;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awready && !aw_done) awvalid <= 1'b0;
            if (wready && !w_done) wvalid <= 1'b0;
            aw_done |= awready;
            w_done |= wready;
        end
        while (!bvalid) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask : axi_rd
    // one whole conversion transaction through the host
    task automatic convert(input logic [7:0] cmd, input logic [1:0] dsel, input logic [15:0] stretch);
        logic [31:0] d;
        logic [1:0]  r;
        stretch_ns <= stretch;
        axi_wr(adc_link_pkg::CTRL_OFS, {15'h0000, 1'b1, 6'h00, dsel, cmd}, r);
        check("go resp", r, adc_link_pkg::RESP_OKAY);
        d = 32'h0000_0000;
        while (d[adc_link_pkg::DONE_BIT] !== 1'b1) axi_rd(adc_link_pkg::STATUS_OFS, d, r);
        check("nack", d[adc_link_pkg::NACK_BIT], dsel != DSEL);
        check("bus idle", in_frame, 1'b0);
        if (dsel == DSEL) begin
            n_conv++;
            check("command", last_cmd, cmd);
            check("read acks", ack_seen, 2'h2);
            axi_rd(adc_link_pkg::RESULT_OFS, d, r);
            check("result", d, exp_result(cmd, n_conv));
        end
        axi_wr(adc_link_pkg::STATUS_OFS, 32'h0000_0006, r);
        axi_rd(adc_link_pkg::STATUS_OFS, d, r);
        check("status", d, 32'h0000_0000);
    endtask : convert
    // main sequence
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            axi_rd(4'(4 * k), d, r);
            check("reset value", d, (k == 3) ? 32'(adc_link_pkg::DIV_RESET) : 32'h0000_0000);
        end
        axi_rd(4'h6, d, r);
        check("unmapped data", d, 32'h0000_0000);
        check("unmapped resp", r, adc_link_pkg::RESP_SLVERR);
        axi_wr(4'h6, 32'hFFFF_FFFF, r);
        check("unmapped write", r, adc_link_pkg::RESP_SLVERR);
        axi_wr(adc_link_pkg::DIV_OFS, 32'h0000_0003, r);
        for (int k = 0; k < 24; k++) begin
            rng = xs(rng);
            convert((k < 16) ? {4'(k), rng[3:0]} : rng[7:0], (k == 20) ? DSEL ^ 2'h1 : DSEL, k[0] ? 16'(rng[23:16]) : 16'h0000);
        end
        print_verdict;
    end
endmodule : adc_host_tb
`default_nettype wire

// ===== test/adc_slave_model.sv
/* behavioural converter slave on the two-wire bus.
   assumes scl and sda are resolved open-drain lines with pull-ups. */
`timescale 1ns/100ps
`default_nettype none
module adc_slave_model #(
    parameter logic [4:0] PREFIX = 5'h0D, // arbitrary prefix value
    parameter logic [1:0] DSEL   = 2'h2   // strapped select pins
) (
    input  wire logic        scl,
    input  wire logic        sda,
    input  wire logic [15:0] stretch_ns,
    output var  logic        scl_low,
    output var  logic        sda_low,
    output var  logic [7:0]  last_cmd,
    output var  logic [1:0]  ack_seen,
    output var  logic        in_frame
);
    logic [7:0]  sh;
    logic [11:0] res = 12'h000; // nothing valid before a command
    logic [2:0]  n_conv = 3'h0;
    logic        ref_on = 1'b0; // reference off after power-up
    logic        hit;
    logic        rd;
    logic [7:0]  tx;
    int          cnt = 0;
    int          phase = 4;     // 0 addr, 1 command, 2 and 3 result bytes, 4 ignore
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        in_frame = 1'b0;
        last_cmd = 8'h00;
        ack_seen = 2'h0;
    end
    // start and stop seen as data moving while clock high
    always @(negedge sda) if (scl === 1'b1) begin
        in_frame = 1'b1;
        cnt = -1;
        phase = 0;
    end
    always @(posedge sda) if (scl === 1'b1) begin
        in_frame = 1'b0;
        phase = 4;
    end
    // sample on the rising clock, msb first
    always @(posedge scl) begin
        if (phase < 2 && cnt >= 0 && cnt < 8) sh = {sh[6:0], sda};
        if (phase == 1 && cnt == 3) n_conv = n_conv + 3'h1; // conversion starts at bit 4
        if (phase >= 2 && phase < 4 && cnt == 8) ack_seen[phase-2] = sda;
    end
    // drive on the falling clock
    always @(negedge scl) if (phase < 4) begin
        cnt = cnt + 1;
        if (cnt == 8) begin
            hit = (phase != 0) || (sh[7:3] == PREFIX && sh[2:1] == DSEL);
            rd = (phase == 0) ? sh[0] : rd;
            if (phase == 1) begin
                last_cmd = sh;
                ref_on = sh[3];
                res = {sh[5:4], sh[6], sh[7] ? 4'h8 : {1'b0, sh[5:4], !sh[6]}, ref_on, sh[2], n_conv};
            end
            sda_low = (phase < 2) && hit; // ack, released while sending
        end else if (cnt == 9) begin
            cnt = 0;
            sda_low = 1'b0;
            if (phase == 0 && rd && hit) begin
                phase = 2;
                scl_low = 1'b1; // hold clock low until the result is ready
            end else if (phase == 0) phase = hit ? 1 : 4;
            else if (phase == 2) phase = ack_seen[0] ? 4 : 3;
            else if (phase == 3) phase = 4;
        end
        if ((phase == 2 || phase == 3) && cnt < 8) begin // result high nibble then low byte
            tx = (phase == 2) ? {4'h0, res[11:8]} : res[7:0];
            sda_low = !tx[7 - cnt];
        end
        // first data bit stands before the stretched clock is let go
        if (scl_low) begin
            #(stretch_ns);
            scl_low = 1'b0;
        end
    end
endmodule : adc_slave_model
`default_nettype wire
